// >>> core/gdrm_bank.v
// Purpose: serial-reached register bank of a three-phase gate driver
// Assumes: link pins arrive asynchronously and are sampled by clk_sys
// Notes:   link clock is slow (125 ns) so edge detection on clk_sys suffices
`timescale 1ns/1ps
`include "gdrm_regs.vh"
module gdrm_bank (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        sel_n,
  input  wire        sclk,
  input  wire        sdi,
  output reg         sdo,
  output wire        sdo_oe,
  input  wire        drain_source_overcurrent,
  input  wire        gate_drive_error,
  input  wire        supply_low_lockout,
  input  wire        overheat_shutdown,
  input  wire        overheat_warning,
  input  wire [5:0]  phase_overcurrent,
  input  wire [10:0] secondary_status_in,
  output reg         error_out_pin_n,
  output wire        latched_error_clear,
  output wire [10:0] driver_control,
  output wire [10:0] high_side_drive_config,
  output wire [10:0] low_side_drive_config,
  output wire [10:0] overcurrent_protect_config,
  output wire [10:0] sense_amplifier_config
);
  reg  [2:0]  sel_sy;
  reg  [2:0]  sclk_sy;
  reg  [1:0]  sdi_sy;
  reg  [10:0] fault_status_primary;
  reg  [10:0] fault_status_secondary;
  reg  [10:0] ctrl_reg;
  reg  [10:0] hs_reg;
  reg  [10:0] ls_reg;
  reg  [10:0] ocp_reg;
  reg  [10:0] csa_reg;
  reg  [15:0] shift_in;
  reg  [15:0] shift_out;
  reg  [4:0]  bit_cnt;
  reg         clr_pulse;
  wire        active;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        frame_end;
  wire [15:0] frame;
  wire        is_write;
  wire [3:0]  addr;
  wire        locked;
  wire [9:0]  fault_bits;
  wire        any_fault;
  reg  [10:0] rd_data;

  // first stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (srst) begin
      sel_sy  <= 3'h7;
      sclk_sy <= 3'h0;
      sdi_sy  <= 2'h0;
    end else begin
      sel_sy  <= {sel_sy[1:0], sel_n};
      sclk_sy <= {sclk_sy[1:0], sclk};
      sdi_sy  <= {sdi_sy[0], sdi};
    end
  end

  assign active    = ~sel_sy[1];
  assign sclk_rise = active & sclk_sy[1] & ~sclk_sy[2];
  assign sclk_fall = active & ~sclk_sy[1] & sclk_sy[2];
  assign frame_end = sel_sy[1] & ~sel_sy[2];
  assign frame     = shift_in;
  assign is_write  = ~frame[`GDRM_RW_BIT];
  assign addr      = frame[`GDRM_ADDR_MSB:`GDRM_ADDR_LSB];
  assign locked    = (hs_reg[`GDRM_HS_LOCK_MSB:`GDRM_HS_LOCK_LSB] == `GDRM_LOCK_ON);

  function [10:0] reg_read;
    input [3:0] a;
    begin
      case (a)
        `GDRM_ADDR_FAULT_PRI: reg_read = fault_status_primary;
        `GDRM_ADDR_FAULT_SEC: reg_read = fault_status_secondary;
        `GDRM_ADDR_DRV_CTRL:  reg_read = ctrl_reg;
        `GDRM_ADDR_HS_CFG:    reg_read = hs_reg;
        `GDRM_ADDR_LS_CFG:    reg_read = ls_reg;
        `GDRM_ADDR_OCP_CFG:   reg_read = ocp_reg;
        `GDRM_ADDR_CSA_CFG:   reg_read = csa_reg;
        default:              reg_read = `GDRM_RST_ZERO;
      endcase
    end
  endfunction

  // address is known after 5 captured bits; contents go out on the next rising edges
  always @* begin
    rd_data = reg_read({shift_in[2:0], sdi_sy[1]});
  end

  // mosi on falling edge, miso on rising edge, msb first
  always @(posedge clk_sys) begin
    if (srst) begin
      shift_in  <= 16'h0000;
      shift_out <= 16'h0000;
      bit_cnt   <= 5'h00;
      sdo       <= 1'b0;
    end else if (!active) begin
      bit_cnt   <= 5'h00;
      shift_out <= 16'h0000;
      sdo       <= 1'b0;
    end else begin
      if (sclk_fall) begin
        shift_in <= {shift_in[14:0], sdi_sy[1]};
        if (bit_cnt != 5'h1f)
          bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'h04)
          shift_out <= {5'h00, rd_data};
      end
      if (sclk_rise) begin
        sdo       <= shift_out[10];
        shift_out <= {shift_out[14:0], 1'b0};
      end
    end
  end
  assign sdo_oe = active;

  // fault word; latched bits held until a clear pulse
  assign fault_bits = {drain_source_overcurrent, gate_drive_error,
                       supply_low_lockout, overheat_shutdown, phase_overcurrent};
  assign any_fault = (|fault_status_primary[9:0]) | (|fault_bits)
                   | (overheat_warning & ctrl_reg[`GDRM_CTRL_OTWREP_BIT]);

  always @(posedge clk_sys) begin
    if (srst) begin
      fault_status_primary   <= `GDRM_RST_ZERO;
      fault_status_secondary <= `GDRM_RST_ZERO;
      error_out_pin_n        <= 1'b1;
    end else begin
      // new faults set even during a clear: set wins
      if (clr_pulse)
        fault_status_primary[9:0] <= fault_bits;
      else
        fault_status_primary[9:0] <= fault_status_primary[9:0] | fault_bits;
      fault_status_primary[`GDRM_FLT_ANY_BIT] <= clr_pulse ?
        ((|fault_bits) | (overheat_warning & ctrl_reg[`GDRM_CTRL_OTWREP_BIT])) : any_fault;
      error_out_pin_n <= clr_pulse ?
        ~((|fault_bits) | (overheat_warning & ctrl_reg[`GDRM_CTRL_OTWREP_BIT])) : ~any_fault;
      fault_status_secondary <= secondary_status_in;
    end
  end

  // writes land at frame end only when exactly 16 bits arrived
  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg  <= `GDRM_RST_DRV_CTRL;
      hs_reg    <= `GDRM_RST_HS_CFG;
      ls_reg    <= `GDRM_RST_LS_CFG;
      ocp_reg   <= `GDRM_RST_OCP_CFG;
      csa_reg   <= `GDRM_RST_CSA_CFG;
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= 1'b0;
      if (ctrl_reg[`GDRM_CTRL_CLR_BIT])
        ctrl_reg[`GDRM_CTRL_CLR_BIT] <= 1'b0;
      if (frame_end && bit_cnt == `GDRM_WORD_BITS && is_write) begin
        case (addr)
          `GDRM_ADDR_DRV_CTRL: begin
            if (locked)
              ctrl_reg[2:0] <= frame[2:0];
            else
              ctrl_reg <= {1'b0, frame[9:0]};
            clr_pulse <= frame[`GDRM_CTRL_CLR_BIT];
          end
          `GDRM_ADDR_HS_CFG: begin
            if (!locked && frame[10:8] == `GDRM_LOCK_ON)
              hs_reg[10:8] <= `GDRM_LOCK_ON;
            else if (locked && frame[10:8] == `GDRM_LOCK_OFF)
              hs_reg[10:8] <= `GDRM_LOCK_OFF;
            if (!locked)
              hs_reg[7:0] <= frame[7:0];
          end
          `GDRM_ADDR_LS_CFG:  if (!locked) ls_reg <= frame[10:0];
          `GDRM_ADDR_OCP_CFG: if (!locked) ocp_reg <= frame[10:0];
          `GDRM_ADDR_CSA_CFG: if (!locked) csa_reg <= frame[10:0];
          // status words and reserved slot ignore writes
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  assign latched_error_clear        = clr_pulse;
  assign driver_control             = ctrl_reg;
  assign high_side_drive_config     = hs_reg;
  assign low_side_drive_config      = ls_reg;
  assign overcurrent_protect_config = ocp_reg;
  assign sense_amplifier_config     = csa_reg;
endmodule // gdrm_bank

// >>> include/gdrm_regs.vh
// Purpose: register map constants for the gate driver register bank
// Assumes: 11-bit registers, 4-bit address, 16-bit serial word
// Notes:   definitions only
`ifndef GDRM_REGS_VH
`define GDRM_REGS_VH
`define GDRM_ADDR_FAULT_PRI   4'h0
`define GDRM_ADDR_FAULT_SEC   4'h1
`define GDRM_ADDR_DRV_CTRL    4'h2
`define GDRM_ADDR_HS_CFG      4'h3
`define GDRM_ADDR_LS_CFG      4'h4
`define GDRM_ADDR_OCP_CFG     4'h5
`define GDRM_ADDR_CSA_CFG     4'h6
`define GDRM_ADDR_RSVD        4'h7
`define GDRM_WORD_BITS        5'h10
`define GDRM_RW_BIT           15
`define GDRM_ADDR_MSB         14
`define GDRM_ADDR_LSB         11
`define GDRM_FLT_ANY_BIT      10
`define GDRM_FLT_OCP_BIT      9
`define GDRM_FLT_GDF_BIT      8
`define GDRM_FLT_SUPPLY_LOW_LOCKOUT_BIT     7
`define GDRM_FLT_OVERHEAT_SHUTDOWN_BIT     6
`define GDRM_CTRL_CLR_BIT     0
`define GDRM_CTRL_OTWREP_BIT  7
`define GDRM_CTRL_RSVD_BIT    10
`define GDRM_HS_LOCK_MSB      10
`define GDRM_HS_LOCK_LSB      8
`define GDRM_LOCK_ON          3'h6
`define GDRM_LOCK_OFF         3'h3
`define GDRM_RST_ZERO         11'h000
`define GDRM_RST_DRV_CTRL     11'h000
`define GDRM_RST_HS_CFG       11'h3ff
`define GDRM_RST_LS_CFG       11'h000
`define GDRM_RST_OCP_CFG      11'h000
`define GDRM_RST_CSA_CFG      11'h000
`endif

// >>> testbench/gdrm_bank_checker.sv
// Purpose: port assertions for gdrm_bank
// Assumes: one clk_sys domain, srst sync high
// Notes:   bound after endmodule
`timescale 1ns/1ps
module gdrm_bank_checker (
  input wire        clk_sys,
  input wire        srst,
  input wire        sel_n,
  input wire        sdo,
  input wire        sdo_oe,
  input wire        drain_source_overcurrent,
  input wire        error_out_pin_n,
  input wire        latched_error_clear,
  input wire [10:0] driver_control,
  input wire [10:0] high_side_drive_config,
  input wire [10:0] low_side_drive_config
);
  default clocking @(posedge clk_sys); endclocking
  // long enough for the sync flops and a landing write
  sequence idle_s; sel_n [*8]; endsequence
  sequence pulse_s; latched_error_clear ##1 !latched_error_clear; endsequence
  pin_follow_a: assert property (disable iff (srst)
    drain_source_overcurrent |-> ##[1:3] !error_out_pin_n) else $error("pin missed fault");
  rst_out_a: assert property (srst |=> error_out_pin_n && !sdo_oe && !sdo)
    else $error("reset outputs wrong");
  rst_cfg_a: assert property (srst |=> high_side_drive_config == 11'h3ff)
    else $error("high side reset wrong");
  ctrl_rsvd_a: assert property (disable iff (srst) !driver_control[10])
    else $error("reserved ctrl bit set");
  clr_pulse_a: assert property (disable iff (srst) latched_error_clear |-> pulse_s)
    else $error("clear pulse too long");
  clr_self_a: assert property (disable iff (srst)
    $rose(driver_control[0]) |-> ##[1:3] !driver_control[0]) else $error("clear bit stuck");
  oe_idle_a: assert property (disable iff (srst) idle_s |-> !sdo_oe)
    else $error("sdo driven while idle");
  cfg_hold_a: assert property (disable iff (srst) idle_s |-> $stable(low_side_drive_config))
    else $error("config moved outside frame");
endmodule // gdrm_bank_checker
bind gdrm_bank gdrm_bank_checker u_chk (.clk_sys(clk_sys), .srst(srst), .sel_n(sel_n),
  .sdo(sdo), .sdo_oe(sdo_oe), .drain_source_overcurrent(drain_source_overcurrent),
  .error_out_pin_n(error_out_pin_n), .latched_error_clear(latched_error_clear),
  .driver_control(driver_control), .high_side_drive_config(high_side_drive_config),
  .low_side_drive_config(low_side_drive_config));

// >>> testbench/gdrm_master.sv
// Purpose: serial link master model
// Assumes: link half period set by hp, default 62.5 ns
// Notes:   callers read the reserved slot but never write it
`timescale 1ns/1ps
module gdrm_master (
  output reg  sel_n,
  output reg  sclk,
  output reg  sdi,
  input  wire sdo
);
  real hp = 62.5;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // no writes to the reserved slot 7h are ever issued
  task automatic xfer(input [15:0] w, input integer nb, output [10:0] r);
    integer i;
    begin
      sel_n = 1'b0;
      // data moves on the rise so it is steady at the capturing fall
      for (i = 15; i > 15 - nb; i = i - 1) begin
        #hp sclk = 1'b1;
        sdi = w[i];
        #hp sclk = 1'b0;
        r = {r[9:0], sdo};
      end
      #hp sel_n = 1'b1;
      sdi = ~sdi;
      #500;
    end
  endtask
endmodule // gdrm_master

// >>> testbench/gdrm_bank_test.sv
// Purpose: register bank bench over the serial link
// Assumes: sdo floats to inverse of last bit when disabled
// Notes:   fault inputs change on clk_sys edges
`timescale 1ns/1ps
module gdrm_bank_test;
  reg        clk_sys = 1'b0;
  reg        srst = 1'b1;
  reg        dso = 1'b0, gde = 1'b0, sll = 1'b0, ohs = 1'b0, ohw = 1'b0;
  reg [5:0]  poc = 6'h00;
  reg [10:0] sec = 11'h0a5;
  reg [10:0] r;
  wire       sel_n, sclk, sdi, sdo, sdo_oe, epn, lec;
  wire [10:0] drv, hs, ls, ocp, csa;
  integer    mismatches = 0;
  integer    num_checks = 0;
  integer    lec_cnt = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (lec) lec_cnt <= lec_cnt + 1;
  gdrm_master u_gdrm_master (.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_oe ? sdo : ~sdo));
  gdrm_bank u_gdrm_bank (.clk_sys(clk_sys), .srst(srst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .drain_source_overcurrent(dso), .gate_drive_error(gde),
    .supply_low_lockout(sll), .overheat_shutdown(ohs), .overheat_warning(ohw),
    .phase_overcurrent(poc), .secondary_status_in(sec), .error_out_pin_n(epn),
    .latched_error_clear(lec), .driver_control(drv), .high_side_drive_config(hs),
    .low_side_drive_config(ls), .overcurrent_protect_config(ocp), .sense_amplifier_config(csa));
  task chk(input [8*5-1:0] n, input [3:0] a, input [10:0] e, input [10:0] s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("FAIL %0s %h exp %h got %h", n, a, e, s);
      end
    end
  endtask
  task rd(input [3:0] a, input [10:0] e);
    begin
      u_gdrm_master.xfer({1'b1, a, 11'h000}, 16, r);
      chk("read", a, e, r);
    end
  endtask
  task wr(input [3:0] a, input [10:0] d, input [10:0] e);
    begin
      u_gdrm_master.xfer({1'b0, a, d}, 16, r);
      chk("write", a, e, r);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #200000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(4'h0, 11'h000);
    rd(4'h3, 11'h3ff);
    rd(4'h2, 11'h000);
    rd(4'h1, 11'h0a5);
    $display("test reset done");
    wr(4'h4, 11'h155, 11'h000);
    wr(4'h0, 11'h7ff, 11'h000);
    wr(4'h1, 11'h7ff, 11'h0a5);
    u_gdrm_master.hp = 100.0;
    rd(4'h4, 11'h155);
    u_gdrm_master.hp = 62.5;
    wr(4'h5, 11'h2aa, 11'h000);
    wr(4'h6, 11'h4d3, 11'h000);
    chk("ocp", 4'h5, 11'h2aa, ocp);
    chk("csa", 4'h6, 11'h4d3, csa);
    rd(4'h7, 11'h000);
    // 15-bit frame must be dropped
    u_gdrm_master.xfer({1'b0, 4'h4, 11'h2aa}, 15, r);
    rd(4'h4, 11'h155);
    $display("test access done");
    @(posedge clk_sys) {dso, gde, sll, poc} <= 9'h1e1;
    repeat (5) @(posedge clk_sys);
    chk("pin", 4'h0, 11'h000, {10'h000, epn});
    {dso, gde, sll, poc} <= 9'h000;
    rd(4'h0, 11'h7a1);
    wr(4'h2, 11'h001, 11'h000);
    rd(4'h0, 11'h000);
    rd(4'h2, 11'h000);
    @(posedge clk_sys) {ohs, poc} <= 7'h5e;
    repeat (5) @(posedge clk_sys);
    poc <= 6'h00;
    rd(4'h0, 11'h45e);
    // fault still present during the clear: set wins
    wr(4'h2, 11'h001, 11'h000);
    rd(4'h0, 11'h440);
    @(posedge clk_sys) ohs <= 1'b0;
    wr(4'h2, 11'h001, 11'h000);
    rd(4'h0, 11'h000);
    chk("clear", 4'h2, 11'h003, lec_cnt[10:0]);
    $display("test fault done");
    @(posedge clk_sys) ohw <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("pin", 4'h0, 11'h001, {10'h000, epn});
    wr(4'h2, 11'h080, 11'h000);
    chk("pin", 4'h0, 11'h000, {10'h000, epn});
    rd(4'h0, 11'h400);
    chk("ctrl", 4'h2, 11'h080, drv);
    wr(4'h2, 11'h480, 11'h080);
    rd(4'h2, 11'h080);
    $display("test warn done");
    wr(4'h3, 11'h6ff, 11'h3ff);
    chk("hs", 4'h3, 11'h6ff, hs);
    wr(4'h4, 11'h0aa, 11'h155);
    rd(4'h4, 11'h155);
    wr(4'h3, 11'h3ff, 11'h6ff);
    wr(4'h3, 11'h6ab, 11'h3ff);
    chk("hs", 4'h3, 11'h6ab, hs);
    // locked: only ctrl bits 2..0 land, bit 0 self-clears
    wr(4'h2, 11'h0c7, 11'h080);
    rd(4'h2, 11'h086);
    chk("clear", 4'h2, 11'h004, lec_cnt[10:0]);
    $display("test lock done");
    @(posedge clk_sys) srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(4'h3, 11'h3ff);
    rd(4'h4, 11'h000);
    rd(4'h0, 11'h000);
    chk("pin", 4'h0, 11'h001, {10'h000, epn});
    $display("test reset again done");
    conclude;
  end
endmodule // gdrm_bank_test
